// *** video_serializer_regs.vh ***
// Constants for the four-channel video serializer transmit path
`ifndef VIDEO_SERIALIZER_REGS_VH
`define VIDEO_SERIALIZER_REGS_VH

// ----------------------------------------------------------------
// Latch bank map
// ----------------------------------------------------------------
`define BANK_COUNT          16
`define BANKS_PER_CHAN      3
`define BANK_GLOBAL_FIRST   4'hc
`define BANK_MASK           4'hf
`define CHAN_BANK_LAST      4'hb

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_GLOBAL_ALLOW    0
`define BIT_GLOBAL_FORCE    0
`define BIT_CLOCK_SELECT    1
`define BIT_HALF_RATE       2
`define BIT_PRIMARY_EN      1
`define BIT_SECONDARY_EN    2
`define BIT_SELFTEST_EN     1
`define BIT_REINIT          2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define INIT_BANK0          5'h03
`define INIT_BANK1          5'h01
`define INIT_BANK2          5'h05
`define INIT_GLOBAL         5'h00
`define INIT_MASK           5'h1f

// ----------------------------------------------------------------
// Data path constants
// ----------------------------------------------------------------
`define ERROR_CHAR          10'h278
`define LFSR_SEED           9'h1ff
`define PHASE_BUF_DEPTH     3'h4
`define PHASE_BUF_CENTER    3'h2
`define PHASE_PTR_CENTER    2'h2
`define SHIFT_BITS          4'ha

`endif

// *** sync_2ff.v ***
// Two-flop synchroniser for a bus of independent levels
`timescale 1ns/1ns
`default_nettype none

module sync_2ff #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input  wire             clk_i,
    input  wire             rst_n_i,
    // Data
    input  wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);

    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] stable_ff;

    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_ff   <= {WIDTH{1'b0}};
            stable_ff <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_ff   <= async_i;
            stable_ff <= meta_ff;
        end
    end

    assign sync_o = stable_ff;

endmodule

`default_nettype wire

// *** selftest_lfsr.v ***
// Nine-bit LFSR giving one self-test character per step
`timescale 1ns/1ns
`default_nettype none
`include "video_serializer_regs.vh"

module selftest_lfsr (
    // Clock and reset
    input  wire       clk_i,
    input  wire       rst_n_i,
    // Control
    input  wire       clear_i,
    input  wire       step_i,
    // Character
    output wire [9:0] char_o
);

    reg  [8:0] state_ff;
    wire       feedback;

    // Taps 9 and 5: maximal length, 511 states
    assign feedback = state_ff[8] ^ state_ff[4];

    always @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            state_ff <= `LFSR_SEED;
        else if (clear_i)
            state_ff <= `LFSR_SEED;
        else if (step_i)
            state_ff <= {state_ff[7:0], feedback};
    end

    assign char_o = {feedback, state_ff};

endmodule

`default_nettype wire

// *** video_serializer_tx.v ***
// Four-channel video serializer transmit path with latch-bank config
`timescale 1ns/1ns
`default_nettype none
`include "video_serializer_regs.vh"

module video_serializer_tx #(
    parameter CHANNELS = 4
) (
    // Clock and reset
    input  wire                  SYS_CLK_I,
    input  wire                  RESET_N_I,
    // Parallel characters and clocks
    input  wire [CHANNELS*10-1:0] CHAR_IN_I,
    input  wire [CHANNELS-1:0]    UPSTREAM_CHAR_CLOCK_I,
    input  wire [CHANNELS-1:0]    CHANNEL_REF_CLOCK_I,
    // Configuration interface
    input  wire                  CFG_WRITE_STROBE_N_I,
    input  wire [3:0]            CFG_ADDR_I,
    input  wire [4:0]            CFG_DATA_I,
    // Serial side
    output wire [CHANNELS-1:0]    SERIAL_OUT_PRIMARY_O,
    output wire [CHANNELS-1:0]    SERIAL_OUT_SECONDARY_O,
    output wire [CHANNELS-1:0]    SERIAL_BIT_VALID_O,
    // Status and clocks out
    output wire [CHANNELS-1:0]    PHASE_BUFFER_ERROR_O,
    output wire [CHANNELS-1:0]    CHAR_CLOCK_OUT_O
);

    // ----------------------------------------------------------------
    // Input synchronisation
    // ----------------------------------------------------------------
    localparam SYNC_W = CHANNELS * 12 + 10;

    wire [SYNC_W-1:0]     sync_out;
    wire [CHANNELS*10-1:0] char_s;
    wire [CHANNELS-1:0]    up_clk_s;
    wire [CHANNELS-1:0]    ref_clk_s;
    wire                  wr_s;
    wire [3:0]            addr_s;
    wire [4:0]            data_s;

    // Strobe inverted ahead of the sync so the reset state means idle
    sync_2ff #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .clk_i   (SYS_CLK_I),
        .rst_n_i (RESET_N_I),
        .async_i ({CHAR_IN_I, UPSTREAM_CHAR_CLOCK_I, CHANNEL_REF_CLOCK_I,
                   ~CFG_WRITE_STROBE_N_I, CFG_ADDR_I, CFG_DATA_I}),
        .sync_o  (sync_out)
    );

    assign char_s    = sync_out[SYNC_W-1 -: CHANNELS*10];
    assign up_clk_s  = sync_out[CHANNELS*2+9 -: CHANNELS];
    assign ref_clk_s = sync_out[CHANNELS+9 -: CHANNELS];
    assign wr_s      = sync_out[9];
    assign addr_s    = sync_out[8:5];
    assign data_s    = sync_out[4:0];

    // ----------------------------------------------------------------
    // Latch banks
    // ----------------------------------------------------------------
    reg  [4:0] bank_ff [0:`BANK_COUNT-1];
    reg        wr_prev_ff;
    wire       wr_start;
    wire [4:0] mask;
    wire [3:0] glob_ofs;
    wire [4:0] merged_addr;
    wire       is_global;
    integer    i;
    integer    k;

    assign mask      = bank_ff[`BANK_MASK];
    assign wr_start  = wr_s & ~wr_prev_ff;
    assign is_global = (addr_s >= `BANK_GLOBAL_FIRST) && (addr_s != `BANK_MASK);
    assign glob_ofs  = addr_s - `BANK_GLOBAL_FIRST;

    // No read path exists; banks are observable only through behaviour
    function [4:0] bank_init;
        input integer idx;
        begin
            if (idx == `BANK_MASK)
                bank_init = `INIT_MASK;
            else if (idx >= `BANK_GLOBAL_FIRST)
                bank_init = `INIT_GLOBAL;
            else if (idx % `BANKS_PER_CHAN == 0)
                bank_init = `INIT_BANK0;
            else if (idx % `BANKS_PER_CHAN == 1)
                bank_init = `INIT_BANK1;
            else
                bank_init = `INIT_BANK2;
        end
    endfunction

    function [4:0] merge;
        input [4:0] old_v;
        input [4:0] new_v;
        input [4:0] m;
        begin
            merge = (new_v & m) | (old_v & ~m);
        end
    endfunction

    assign merged_addr = merge(bank_ff[addr_s], data_s, mask);

    always @(posedge SYS_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            wr_prev_ff <= 1'b0;
            for (i = 0; i < `BANK_COUNT; i = i + 1)
                bank_ff[i] <= bank_init(i);
        end
        else
        begin
            wr_prev_ff <= wr_s;
            // Level-sensitive: repeats while strobe is low, idempotent
            if (wr_s)
            begin
                if (addr_s == `BANK_MASK)
                    bank_ff[`BANK_MASK] <= data_s;
                else if (is_global)
                begin
                    // Force bit lands unmasked so it can always be withdrawn
                    bank_ff[addr_s] <= {merged_addr[4:1], data_s[`BIT_GLOBAL_FORCE]};
                    for (k = 0; k < CHANNELS; k = k + 1)
                    begin
                        // Allow bit of a target is never touched by a global write
                        if (bank_ff[k*`BANKS_PER_CHAN + glob_ofs][`BIT_GLOBAL_ALLOW] |
                            data_s[`BIT_GLOBAL_FORCE])
                            bank_ff[k*`BANKS_PER_CHAN + glob_ofs][4:1] <=
                                (data_s[4:1] & mask[4:1]) |
                                (bank_ff[k*`BANKS_PER_CHAN + glob_ofs][4:1] & ~mask[4:1]);
                    end
                end
                else
                    bank_ff[addr_s] <= merged_addr;
            end
        end
    end

    // ----------------------------------------------------------------
    // Channels
    // ----------------------------------------------------------------
    genvar c;
    generate
        for (c = 0; c < CHANNELS; c = c + 1)
        begin : g_chan
            localparam [3:0] B0 = c * `BANKS_PER_CHAN;
            localparam [3:0] B1 = c * `BANKS_PER_CHAN + 1;
            localparam [3:0] B2 = c * `BANKS_PER_CHAN + 2;

            wire       clk_sel   = bank_ff[B0][`BIT_CLOCK_SELECT];
            wire       half_rate = bank_ff[B0][`BIT_HALF_RATE];
            wire       prim_en   = bank_ff[B1][`BIT_PRIMARY_EN];
            wire       sec_en    = bank_ff[B1][`BIT_SECONDARY_EN];
            wire       selftest  = bank_ff[B2][`BIT_SELFTEST_EN];
            wire       chan_on   = prim_en | sec_en;
            wire [9:0] char_now  = char_s[c*10 +: 10];
            wire       reinit_hit;
            wire       reinit;

            // Reinit is a write event that leaves the latch bit at 0
            assign reinit_hit = (addr_s == B2) ||
                                ((addr_s == `BANK_GLOBAL_FIRST + 4'h2) &&
                                 (bank_ff[B2][`BIT_GLOBAL_ALLOW] |
                                  data_s[`BIT_GLOBAL_FORCE]));
            assign reinit = wr_start & reinit_hit & mask[`BIT_REINIT] &
                            ~data_s[`BIT_REINIT];

            // ----------------------------------------------------------------
            // Phase-align buffer, input register and shifter state
            // ----------------------------------------------------------------
            reg        ref_prev_ff;
            reg        up_prev_ff;
            reg        char_stb_ff;
            reg [9:0]  buf_ff [0:3];
            reg [1:0]  wptr_ff;
            reg [1:0]  rptr_ff;
            reg [2:0]  fill_ff;
            reg        err_ff;
            reg [9:0]  shift_ff;
            reg [3:0]  bits_left_ff;
            reg [9:0]  direct_ff;
            reg        pri_ff;
            reg        sec_ff;
            reg        valid_ff;

            wire ref_rise = ref_clk_s[c] & ~ref_prev_ff;
            wire ref_fall = ~ref_clk_s[c] & ref_prev_ff;
            wire up_rise  = up_clk_s[c] & ~up_prev_ff;
            // Half-rate reference gives a character on both edges
            wire char_stb = ref_rise | (half_rate & ref_fall);
            wire use_buf  = ~clk_sel;
            wire buf_wr   = use_buf & up_rise & ~selftest;
            wire buf_rd   = use_buf & char_stb & ~selftest;
            wire over     = buf_wr & ~buf_rd & (fill_ff == `PHASE_BUF_DEPTH);
            wire under    = buf_rd & ~buf_wr & (fill_ff == 3'h0);
            wire [9:0] lfsr_char;

            selftest_lfsr u_lfsr (
                .clk_i   (SYS_CLK_I),
                .rst_n_i (RESET_N_I),
                .clear_i (~selftest | ~chan_on),
                .step_i  (char_stb),
                .char_o  (lfsr_char)
            );

            // ----------------------------------------------------------------
            // Character source
            // ----------------------------------------------------------------
            // Character chosen for the next load
            reg [9:0] next_char;
            always @*
            begin
                next_char = direct_ff;
                if (err_ff)
                    next_char = `ERROR_CHAR;
                else if (selftest)
                    next_char = lfsr_char;
                else if (use_buf)
                    next_char = buf_ff[rptr_ff];
            end

            // ----------------------------------------------------------------
            // Transmit shifter
            // ----------------------------------------------------------------
            reg [9:0] nxt_shift;
            reg [3:0] nxt_bits_left;
            wire      nxt_valid;

            always @*
            begin
                nxt_shift     = shift_ff;
                nxt_bits_left = bits_left_ff;
                if (char_stb)
                begin
                    nxt_shift     = next_char;
                    nxt_bits_left = `SHIFT_BITS;
                end
                else if (bits_left_ff != 4'h0)
                begin
                    // LSB leaves first; zeros fill behind it
                    nxt_shift     = {1'b0, shift_ff[9:1]};
                    nxt_bits_left = bits_left_ff - 4'h1;
                end
            end

            assign nxt_valid = nxt_bits_left != 4'h0;

            // ----------------------------------------------------------------
            // Clocked channel state
            // ----------------------------------------------------------------

            always @(posedge SYS_CLK_I or negedge RESET_N_I)
            begin
                if (!RESET_N_I)
                begin
                    ref_prev_ff  <= 1'b0;
                    up_prev_ff   <= 1'b0;
                    char_stb_ff  <= 1'b0;
                    wptr_ff      <= 2'h0;
                    rptr_ff      <= 2'h0;
                    fill_ff      <= `PHASE_BUF_CENTER;
                    err_ff       <= 1'b0;
                    shift_ff     <= 10'h000;
                    bits_left_ff <= 4'h0;
                    direct_ff    <= 10'h000;
                    pri_ff       <= 1'b0;
                    sec_ff       <= 1'b0;
                    valid_ff     <= 1'b0;
                    buf_ff[0]    <= 10'h000;
                    buf_ff[1]    <= 10'h000;
                    buf_ff[2]    <= 10'h000;
                    buf_ff[3]    <= 10'h000;
                end
                else if (!chan_on)
                begin
                    // Powered down: shifter and outputs cleared; phase buffer, pointers and error state held
                    ref_prev_ff  <= ref_clk_s[c];
                    up_prev_ff   <= up_clk_s[c];
                    char_stb_ff  <= 1'b0;
                    pri_ff       <= 1'b0;
                    sec_ff       <= 1'b0;
                    valid_ff     <= 1'b0;
                    shift_ff     <= 10'h000;
                    bits_left_ff <= 4'h0;
                end
                else
                begin
                    ref_prev_ff <= ref_clk_s[c];
                    up_prev_ff  <= up_clk_s[c];
                    char_stb_ff <= char_stb;
                    // Reference-clocked capture directly into input register
                    if (clk_sel & char_stb & ~selftest)
                        direct_ff <= char_now;
                    if (buf_wr)
                    begin
                        buf_ff[wptr_ff] <= char_now;
                        wptr_ff         <= wptr_ff + 2'h1;
                    end
                    if (buf_rd)
                        rptr_ff <= rptr_ff + 2'h1;
                    if (reinit)
                    begin
                        // Recentre so write leads read by half the buffer
                        wptr_ff <= rptr_ff + `PHASE_PTR_CENTER;
                        fill_ff <= `PHASE_BUF_CENTER;
                        // A slip seen in the same cycle still wins over the clear
                        err_ff  <= over | under;
                    end
                    else
                    begin
                        if (buf_wr & ~buf_rd & ~over)
                            fill_ff <= fill_ff + 3'h1;
                        else if (buf_rd & ~buf_wr & ~under)
                            fill_ff <= fill_ff - 3'h1;
                        if (over | under)
                            err_ff <= 1'b1;
                    end
                    shift_ff     <= nxt_shift;
                    bits_left_ff <= nxt_bits_left;
                    pri_ff       <= nxt_shift[0] & prim_en & nxt_valid;
                    sec_ff       <= nxt_shift[0] & sec_en & nxt_valid;
                    valid_ff     <= nxt_valid;
                end
            end

            // ----------------------------------------------------------------
            // Outputs
            // ----------------------------------------------------------------
            // Both drivers share the shifter output
            assign SERIAL_OUT_PRIMARY_O[c]   = pri_ff;
            assign SERIAL_OUT_SECONDARY_O[c] = sec_ff;
            assign SERIAL_BIT_VALID_O[c]     = valid_ff;
            assign PHASE_BUFFER_ERROR_O[c]   = err_ff;
            assign CHAR_CLOCK_OUT_O[c]       = char_stb_ff;
        end
    endgenerate

endmodule

`default_nettype wire

// *** video_serializer_tx_checker.sv ***
// Port-level assertions for the video serializer transmit path
`timescale 1ns/1ns
`default_nettype none

module video_serializer_tx_checker #(
    parameter CHANNELS = 4
) (
    // Clock and reset
    input wire logic                SYS_CLK_I,
    input wire logic                RESET_N_I,
    // Configuration strobe
    input wire logic                CFG_WRITE_STROBE_N_I,
    // Outputs watched
    input wire logic [CHANNELS-1:0] SERIAL_OUT_PRIMARY_O,
    input wire logic [CHANNELS-1:0] SERIAL_OUT_SECONDARY_O,
    input wire logic [CHANNELS-1:0] SERIAL_BIT_VALID_O,
    input wire logic [CHANNELS-1:0] PHASE_BUFFER_ERROR_O,
    input wire logic [CHANNELS-1:0] CHAR_CLOCK_OUT_O
);
    logic [7:0] since_wr_ff;

    // ------------------------------------------------------------
    // Cycles since the strobe was last low
    // ------------------------------------------------------------
    // Only a recent write may clear the error
    always @(posedge SYS_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
            since_wr_ff <= 8'h00;
        else if (!CFG_WRITE_STROBE_N_I)
            since_wr_ff <= 8'h00;
        else if (since_wr_ff != 8'hff)
            since_wr_ff <= since_wr_ff + 8'h01;
    end

    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RESET_N_I);

    property p_idle;
        $rose(RESET_N_I) |-> ~|(SERIAL_OUT_PRIMARY_O | SERIAL_OUT_SECONDARY_O);
    endproperty
    a_idle: assert property (p_idle) else $error("driver active at reset");
    property p_pri_gate;
        ~|(SERIAL_OUT_PRIMARY_O & ~SERIAL_BIT_VALID_O);
    endproperty
    a_pri_gate: assert property (p_pri_gate) else $error("primary bit off frame");
    property p_sec_gate;
        ~|(SERIAL_OUT_SECONDARY_O & ~SERIAL_BIT_VALID_O);
    endproperty
    a_sec_gate: assert property (p_sec_gate) else $error("secondary bit off frame");
    property p_pulse;
        CHAR_CLOCK_OUT_O[0] |=> !CHAR_CLOCK_OUT_O[0];
    endproperty
    a_pulse: assert property (p_pulse) else $error("char clock too long");
    property p_ten_bits;
        $rose(SERIAL_BIT_VALID_O[0]) |-> SERIAL_BIT_VALID_O[0] [*8]
            ##1 SERIAL_BIT_VALID_O[0] [*2] ##1 !SERIAL_BIT_VALID_O[0];
    endproperty
    a_ten_bits: assert property (p_ten_bits) else $error("frame not ten bits");
    property p_char_start;
        $rose(SERIAL_BIT_VALID_O[0]) |-> CHAR_CLOCK_OUT_O[0];
    endproperty
    a_char_start: assert property (p_char_start) else $error("no char clock");
    property p_err_clear;
        $fell(PHASE_BUFFER_ERROR_O[0]) |-> since_wr_ff < 8'h08;
    endproperty
    a_err_clear: assert property (p_err_clear) else $error("error cleared alone");
    property p_err_hold;
        PHASE_BUFFER_ERROR_O[0] && since_wr_ff > 8'h08 |=> PHASE_BUFFER_ERROR_O[0];
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("error not sticky");
endmodule

bind video_serializer_tx video_serializer_tx_checker #(.CHANNELS(CHANNELS)) chk_u (
    .SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I),
    .CFG_WRITE_STROBE_N_I(CFG_WRITE_STROBE_N_I),
    .SERIAL_OUT_PRIMARY_O(SERIAL_OUT_PRIMARY_O),
    .SERIAL_OUT_SECONDARY_O(SERIAL_OUT_SECONDARY_O),
    .SERIAL_BIT_VALID_O(SERIAL_BIT_VALID_O),
    .PHASE_BUFFER_ERROR_O(PHASE_BUFFER_ERROR_O),
    .CHAR_CLOCK_OUT_O(CHAR_CLOCK_OUT_O));
`default_nettype wire

// *** video_source_model.sv ***
// Upstream clock source: reference and upstream character clocks
`timescale 1ns/1ns
`default_nettype none

module video_source_model (
    // Control
    input  wire logic       up_run_i,
    // Clocks
    output wire logic [3:0] ref_clk_o,
    output wire logic [3:0] up_clk_o
);
    logic ref_ff;
    logic up_ff;

    // Full-rate reference, 125 ns, off the system clock grid
    initial
    begin
        ref_ff = 1'b0;
        #2;
        forever
        begin
            ref_ff = 1'b1;
            #62;
            ref_ff = 1'b0;
            #63;
        end
    end

    // Same rate, fixed lag; stops dead when not running
    initial up_ff = 1'b0;
    always @(ref_ff) up_ff <= #37 ref_ff & up_run_i;

    assign ref_clk_o = {4{ref_ff}};
    assign up_clk_o  = {4{up_ff}};
endmodule
`default_nettype wire

// *** test_video_serializer_tx.sv ***
// Self-checking bench for the video serializer transmit path
`timescale 1ns/1ns
`default_nettype none

module test_video_serializer_tx;
    logic        SYS_CLK_I;
    logic        RESET_N_I;
    logic [39:0] CHAR_IN_I;
    logic        CFG_WRITE_STROBE_N_I;
    logic [3:0]  CFG_ADDR_I;
    logic [4:0]  CFG_DATA_I;
    wire  [3:0]  SERIAL_OUT_PRIMARY_O, SERIAL_OUT_SECONDARY_O;
    wire  [3:0]  SERIAL_BIT_VALID_O, PHASE_BUFFER_ERROR_O, CHAR_CLOCK_OUT_O;
    wire  [3:0]  ref_clk, up_clk;
    logic [15:0] lfsr = 16'h0055;
    logic [47:0] rtmp;
    logic [19:0] exp_q[$];
    logic [19:0] e;
    logic [9:0]  ec, shp, shs, last_char, c0, prev_c;
    logic        up_run, watch, take, p_on, s_on, err_mode;
    int          arm, nb, k, errors, num_checks;
    event        chr_ev;

    video_serializer_tx dut_u (
        .SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I), .CHAR_IN_I(CHAR_IN_I),
        .UPSTREAM_CHAR_CLOCK_I(up_clk), .CHANNEL_REF_CLOCK_I(ref_clk),
        .CFG_WRITE_STROBE_N_I(CFG_WRITE_STROBE_N_I), .CFG_ADDR_I(CFG_ADDR_I),
        .CFG_DATA_I(CFG_DATA_I), .SERIAL_OUT_PRIMARY_O(SERIAL_OUT_PRIMARY_O),
        .SERIAL_OUT_SECONDARY_O(SERIAL_OUT_SECONDARY_O),
        .SERIAL_BIT_VALID_O(SERIAL_BIT_VALID_O),
        .PHASE_BUFFER_ERROR_O(PHASE_BUFFER_ERROR_O),
        .CHAR_CLOCK_OUT_O(CHAR_CLOCK_OUT_O));
    video_source_model partner_u (.up_run_i(up_run), .ref_clk_o(ref_clk), .up_clk_o(up_clk));

    initial
    begin
        SYS_CLK_I = 1'b0;
        forever #5 SYS_CLK_I = ~SYS_CLK_I;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction
    task automatic note(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_char(input logic [9:0] got, input logic [9:0] exp);
        note({22'h0, got}, {22'h0, exp});
    endtask
    task automatic chk_flags(input logic [3:0] got, input logic [3:0] exp);
        note({28'h0, got}, {28'h0, exp});
    endtask
    task automatic chk_count(input int got, input int exp);
        note(got, exp);
    endtask
    task automatic cfg(input logic [3:0] a, input logic [4:0] d);
        @(negedge SYS_CLK_I);
        CFG_ADDR_I = a;
        CFG_DATA_I = d;
        CFG_WRITE_STROBE_N_I = 1'b0;
        repeat (3) @(negedge SYS_CLK_I);
        CFG_WRITE_STROBE_N_I = 1'b1;
        repeat (4) @(negedge SYS_CLK_I);
    endtask
    // Arms n characters; the watcher compares them as they leave
    task automatic run(input int n);
        // Let one character settle in the input register before arming
        repeat (2) @(negedge ref_clk[0]);
        arm = n;
        repeat (n + 3) @(negedge ref_clk[0]);
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Driver: new character mid reference period, safe from capture
    // ------------------------------------------------------------
    always @(negedge ref_clk[0])
    begin
        @(negedge SYS_CLK_I);
        rtmp = {rnd(), rnd(), rnd()};
        // Input register adds one character of latency
        prev_c = CHAR_IN_I[9:0];
        CHAR_IN_I = rtmp[39:0];
        watch = (arm > 0);
        if (arm > 0)
        begin
            ec = err_mode ? 10'h278 : prev_c;
            exp_q.push_back({s_on ? ec : 10'h000, p_on ? ec : 10'h000});
            arm--;
        end
    end

    // ------------------------------------------------------------
    // Watcher: gathers ten bits of channel 0, LSB first
    // ------------------------------------------------------------
    always @(negedge SYS_CLK_I)
    begin
        if (SERIAL_BIT_VALID_O[0] === 1'b1)
        begin
            if (nb == 0)
                take = watch;
            shp[nb] = SERIAL_OUT_PRIMARY_O[0];
            shs[nb] = SERIAL_OUT_SECONDARY_O[0];
            nb++;
            if (nb == 10)
            begin
                nb = 0;
                last_char = shp;
                ->chr_ev;
                if (take)
                begin
                    e = (exp_q.size() > 0) ? exp_q.pop_front() : 20'hfffff;
                    chk_char(shp, e[9:0]);
                    chk_char(shs, e[19:10]);
                end
            end
        end
        else
            nb = 0;
    end

    initial
    begin
        #400000;
        errors++;
        test_done();
    end

    initial
    begin
        RESET_N_I = 1'b0;
        CHAR_IN_I = 40'h0;
        CFG_WRITE_STROBE_N_I = 1'b1;
        CFG_ADDR_I = 4'h0;
        CFG_DATA_I = 5'h00;
        {up_run, watch, take, p_on, s_on, err_mode} = 6'h20;
        {arm, nb, errors, num_checks} = '0;
        repeat (6) @(negedge SYS_CLK_I);
        RESET_N_I = 1'b1;
        repeat (30) @(negedge SYS_CLK_I);
        chk_flags(SERIAL_OUT_PRIMARY_O | SERIAL_OUT_SECONDARY_O, 4'h0);
        chk_flags(PHASE_BUFFER_ERROR_O, 4'h0);
        cfg(4'hd, 5'h06);
        {p_on, s_on} = 2'h3;
        run(5);
        cfg(4'hf, 5'h1b);
        cfg(4'h1, 5'h01);
        p_on = 1'b0;
        run(3);
        cfg(4'hf, 5'h1f);
        cfg(4'h1, 5'h02);
        cfg(4'hd, 5'h06);
        {p_on, s_on} = 2'h2;
        run(3);
        cfg(4'hd, 5'h07);
        s_on = 1'b1;
        run(3);
        cfg(4'hd, 5'h04);
        run(3);
        cfg(4'h2, 5'h07);
        repeat (4) @(chr_ev);
        c0 = last_char;
        k = 0;
        do
        begin
            @(chr_ev);
            k++;
        end while (last_char !== c0 && k < 600);
        chk_count(k, 511);
        cfg(4'h2, 5'h05);
        cfg(4'h0, 5'h01);
        cfg(4'h2, 5'h01);
        repeat (16) @(negedge ref_clk[0]);
        chk_flags(PHASE_BUFFER_ERROR_O, 4'h0);
        up_run = 1'b0;
        repeat (6) @(negedge ref_clk[0]);
        chk_flags(PHASE_BUFFER_ERROR_O, 4'h1);
        err_mode = 1'b1;
        run(4);
        err_mode = 1'b0;
        up_run = 1'b1;
        cfg(4'h2, 5'h01);
        repeat (6) @(negedge ref_clk[0]);
        chk_flags(PHASE_BUFFER_ERROR_O, 4'h0);
        chk_count(exp_q.size(), 0);
        test_done();
    end
endmodule
`default_nettype wire
